//--- logic/cxe_pkg.sv
/*
 * cxe_pkg: constants, types and helpers for the clear/call/inc/dec
 * execution core.
 * assumes one 20 MHz core clock and an APB master on the same clock.
 */
// Function
// RULE1: clear-working loads 00h into working register and sets zero flag.
// RULE2: call first pushes program counter plus one onto stack top.
// RULE3: call loads its eight-bit operand into program counter bits 7..0.
// RULE4: call copies status bits 6:5 to counter bits 10:9, clears bit 8.
// RULE5: call takes two instruction cycles and changes no status flag.
// RULE6: clear-watchdog zeroes watchdog count, sets timeout and power-down flags.
// RULE7: clear-watchdog clears prescaler only when assigned to the watchdog.
// RULE8: clear-file writes 00h into addressed file register and sets zero.
// RULE9: destination bit 0 sends result to working, 1 back to file.
// RULE10: complement-file inverts register, sends to destination, updates zero.
// RULE11: decrement-file subtracts one, sends to destination, updates only zero.
// RULE12: increment-file adds one, sends to destination, updates only zero.
// RULE13: inc/dec wrap modulo 256; carry and digit carry untouched.
package cxe_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int DW = 8;
	localparam int AW = 5;
	localparam int PCW = 11;
	localparam int APB_AW = 12;
	localparam int STACK_DEPTH = 2;
	localparam int FILES = 32;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [APB_AW-1:0] ADDR_INSTR = 12'h000;
	localparam logic [APB_AW-1:0] ADDR_WREG = 12'h004;
	localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h008;
	localparam logic [APB_AW-1:0] ADDR_PC = 12'h00C;
	localparam logic [APB_AW-1:0] ADDR_STACK = 12'h010;
	localparam logic [APB_AW-1:0] ADDR_WDT = 12'h014;
	localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h018;
	localparam logic [APB_AW-1:0] ADDR_FILE_BASE = 12'h080;
	localparam logic [APB_AW-1:0] FILE_REGION_MASK = 12'hF80;
	localparam int FILE_IDX_LSB = 2;

	// ----------------------------------------------------------------
	// instruction word fields
	// ----------------------------------------------------------------
	localparam int INS_OP_LSB = 0;
	localparam int INS_OP_W = 4;
	localparam int INS_FILE_LSB = 4;
	localparam int INS_DEST_BIT = 9;
	localparam int INS_K_LSB = 16;

	// ----------------------------------------------------------------
	// status, control and watchdog fields
	// ----------------------------------------------------------------
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam int ST_PD = 3;
	localparam int ST_TO = 4;
	localparam int ST_PA_LO = 5;
	localparam int ST_PA_HI = 6;
	localparam logic [DW-1:0] STATUS_RESET = 8'h18;
	localparam logic [DW-1:0] STATUS_SW_MASK = 8'hE7;
	localparam int CTRL_PSA = 0;
	localparam int CTRL_BUSY = 1;
	localparam int WDT_PRE_LSB = 8;
	localparam int PC_BIT8 = 8;
	localparam int PC_HI_LSB = 9;
	localparam logic [DW-1:0] ZERO8 = 8'h00;
	localparam logic [DW-1:0] ONE8 = 8'h01;
	localparam logic [DW-1:0] ALL8 = 8'hFF;
	localparam logic [PCW-1:0] PC_STEP = 11'h001;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_CLEAR_WORKING_INSTR = 4'h1,
		OP_CLEAR_FILE_INSTR = 4'h2,
		OP_COMPLEMENT_FILE_INSTR = 4'h3,
		OP_DECREMENT_FILE_INSTR = 4'h4,
		OP_INCREMENT_FILE_INSTR = 4'h5,
		OP_CALL = 4'h6,
		OP_CLEAR_WATCHDOG_INSTR = 4'h7
	} cxe_op_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_CALL2 = 2'b01
	} cxe_state_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [APB_AW-1:0] paddr;
		logic [31:0] pwdata;
	} cxe_apb_req_t;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} cxe_apb_rsp_t;

	typedef struct packed {
		logic [DW-1:0] result;
		logic zero;
		logic toWorking;
	} cxe_alu_out_t;

	typedef struct packed {
		cxe_state_t state;
		logic [DW-1:0] w;
		logic [DW-1:0] status;
		logic [PCW-1:0] pc;
		logic [STACK_DEPTH-1:0][PCW-1:0] stack;
		logic [DW-1:0] callK;
		logic [DW-1:0] wdt;
		logic [DW-1:0] pre;
		logic psaWdt;
		logic [FILES-1:0][DW-1:0] files;
		logic [31:0] rdata;
		logic err;
	} cxe_core_t;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic isZero(input logic [DW-1:0] v);
		return v == ZERO8;
	endfunction

	function automatic logic isFileAddr(input logic [APB_AW-1:0] a);
		return (a & FILE_REGION_MASK) == ADDR_FILE_BASE;
	endfunction

endpackage

//--- logic/cxe_alu.sv
/*
 * cxe_alu: combinational result path for clear, complement,
 * decrement and increment of one byte.
 * assumes the caller writes the result where toWorking points.
 */
module cxe_alu
	import cxe_pkg::*;
(
	input wire cxe_op_t op,
	input wire logic [DW-1:0] operand,
	input wire logic destFile,
	output cxe_alu_out_t out
);

	// ----------------------------------------------------------------
	// result and zero
	// ----------------------------------------------------------------
	always_comb begin
		out.result = operand;
		out.toWorking = ~destFile; // RULE9
		case (op)
			OP_CLEAR_WORKING_INSTR: begin
				out.result = ZERO8; // RULE1
				out.toWorking = 1'b1;
			end
			OP_CLEAR_FILE_INSTR: begin
				out.result = ZERO8; // RULE8
				out.toWorking = 1'b0;
			end
			OP_COMPLEMENT_FILE_INSTR: out.result = ~operand; // RULE10
			OP_DECREMENT_FILE_INSTR: out.result = operand - ONE8; // RULE11 RULE13
			OP_INCREMENT_FILE_INSTR: out.result = operand + ONE8; // RULE12 RULE13
			default: out.result = operand;
		endcase
		out.zero = isZero(out.result);
	end

endmodule // cxe_alu

//--- logic/cxe_exec_core.sv
/*
 * cxe_exec_core: executes clear, call, watchdog-clear, complement,
 * decrement and increment instructions written over APB.
 * assumes an APB master on core_clk; instruction words come in
 * through the instruction register.
 */
module cxe_exec_core
	import cxe_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire cxe_apb_req_t apbReq,
	output cxe_apb_rsp_t apbRsp
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	cxe_core_t st;
	cxe_core_t next_st;
	cxe_alu_out_t aluOut;
	cxe_op_t opIn;
	logic [AW-1:0] fileIn;
	logic destIn;
	logic [DW-1:0] kIn;
	logic [DW-1:0] operand;
	logic idle;
	logic xferDone;
	logic wrDone;
	logic instrGo;
	logic [AW-1:0] busFile;
	logic preWrap;
	logic [31:0] readMux;
	logic readErr;

	assign idle = (st.state == S_IDLE);
	assign xferDone = apbReq.psel && apbReq.penable && idle;
	assign wrDone = xferDone && apbReq.pwrite;
	assign instrGo = wrDone && (apbReq.paddr == ADDR_INSTR);
	assign opIn = cxe_op_t'(apbReq.pwdata[INS_OP_LSB +: INS_OP_W]);
	assign fileIn = apbReq.pwdata[INS_FILE_LSB +: AW];
	assign destIn = apbReq.pwdata[INS_DEST_BIT];
	assign kIn = apbReq.pwdata[INS_K_LSB +: DW];
	assign operand = st.files[fileIn];
	assign busFile = apbReq.paddr[FILE_IDX_LSB +: AW];
	assign preWrap = (st.pre == ALL8);

	// ----------------------------------------------------------------
	// apb response
	// ----------------------------------------------------------------
	assign apbRsp = '{pready: idle, prdata: st.rdata,
		pslverr: st.err && apbReq.penable};

	cxe_alu u_alu (
		.op(opIn),
		.operand(operand),
		.destFile(destIn),
		.out(aluOut)
	);

	// ----------------------------------------------------------------
	// read decode
	// ----------------------------------------------------------------
	always_comb begin
		readMux = 32'h0000_0000;
		readErr = 1'b0;
		if (isFileAddr(apbReq.paddr)) begin
			readMux[DW-1:0] = st.files[busFile];
		end else begin
			case (apbReq.paddr)
				ADDR_INSTR: readMux = 32'h0000_0000;
				ADDR_WREG: readMux[DW-1:0] = st.w;
				ADDR_STATUS: readMux[DW-1:0] = st.status;
				ADDR_PC: readMux[PCW-1:0] = st.pc;
				ADDR_STACK: readMux[PCW-1:0] = st.stack[0];
				ADDR_WDT: begin
					readMux[DW-1:0] = st.wdt;
					readMux[WDT_PRE_LSB +: DW] = st.pre;
				end
				ADDR_CTRL: begin
					readMux[CTRL_PSA] = st.psaWdt;
					readMux[CTRL_BUSY] = ~idle;
				end
				default: readErr = 1'b1;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		// read data is captured before the completing edge
		if (apbReq.psel && !xferDone) begin
			next_st.rdata = readMux;
			next_st.err = readErr;
		end

		// free-running watchdog and prescaler
		next_st.pre = st.pre + ONE8;
		if (!st.psaWdt || preWrap) begin
			next_st.wdt = st.wdt + ONE8;
			if (st.wdt == ALL8) begin
				next_st.status[ST_TO] = 1'b0;
			end
		end

		// software register writes
		if (wrDone && !instrGo) begin
			if (isFileAddr(apbReq.paddr)) begin
				next_st.files[busFile] = apbReq.pwdata[DW-1:0];
			end else begin
				case (apbReq.paddr)
					ADDR_WREG: next_st.w = apbReq.pwdata[DW-1:0];
					ADDR_STATUS: begin
						next_st.status = (next_st.status
							& ~STATUS_SW_MASK)
							| (apbReq.pwdata[DW-1:0] & STATUS_SW_MASK);
					end
					ADDR_PC: next_st.pc = apbReq.pwdata[PCW-1:0];
					ADDR_CTRL: next_st.psaWdt = apbReq.pwdata[CTRL_PSA];
					default: next_st.w = st.w;
				endcase
			end
		end

		// instruction execution
		case (st.state)
			S_IDLE: begin
				if (instrGo) begin
					next_st.pc = st.pc + PC_STEP;
					case (opIn)
						OP_CLEAR_WORKING_INSTR, OP_CLEAR_FILE_INSTR, OP_COMPLEMENT_FILE_INSTR, OP_DECREMENT_FILE_INSTR, OP_INCREMENT_FILE_INSTR: begin
							if (aluOut.toWorking) begin
								next_st.w = aluOut.result; // RULE9
							end else begin
								next_st.files[fileIn] = aluOut.result; // RULE9
							end
							// only zero moves; carry bits stay
							next_st.status[ST_Z] = aluOut.zero; // RULE13
						end
						OP_CALL: begin
							next_st.stack[1] = st.stack[0];
							next_st.stack[0] = st.pc + PC_STEP; // RULE2
							next_st.pc = st.pc;
							next_st.callK = kIn;
							next_st.state = S_CALL2; // RULE5
						end
						OP_CLEAR_WATCHDOG_INSTR: begin
							next_st.wdt = ZERO8; // RULE6
							next_st.status[ST_TO] = 1'b1; // RULE6
							next_st.status[ST_PD] = 1'b1; // RULE6
							if (st.psaWdt) begin
								next_st.pre = ZERO8; // RULE7
							end
						end
						default: next_st.w = st.w;
					endcase
				end
			end
			S_CALL2: begin
				next_st.pc[DW-1:0] = st.callK; // RULE3
				next_st.pc[PC_BIT8] = 1'b0; // RULE4
				next_st.pc[PC_HI_LSB +: ST_PA_HI - ST_PA_LO + 1] =
					st.status[ST_PA_HI:ST_PA_LO]; // RULE4
				next_st.state = S_IDLE; // RULE5
			end
			default: next_st.state = S_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
			st.state <= S_IDLE;
			st.status <= STATUS_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	sequence callIssued;
		instrGo && (opIn == OP_CALL);
	endsequence

	sequence callSecond;
		st.state == S_CALL2;
	endsequence

	a_clear_working_instr_clears_w: assert property ( // RULE1
		instrGo && opIn == OP_CLEAR_WORKING_INSTR |=> st.w == ZERO8 && st.status[ST_Z])
		else $error("working register not cleared with zero set");

	a_call_push_ret: assert property ( // RULE2
		callIssued |=> st.stack[0] == $past(st.pc) + PC_STEP
			&& st.stack[1] == $past(st.stack[0]))
		else $error("call return address not pushed");

	a_call_low_pc: assert property ( // RULE3
		callIssued ##1 callSecond |=> st.pc[DW-1:0] == $past(kIn, 2))
		else $error("call operand not in low counter bits");

	a_call_high_pc: assert property ( // RULE4
		callIssued |-> ##2 st.pc[PC_HI_LSB +: 2]
			== $past(st.status[ST_PA_HI:ST_PA_LO], 2)
			&& !st.pc[PC_BIT8])
		else $error("call upper counter bits wrong");

	a_call_two_cyc: assert property ( // RULE5
		callIssued |=> callSecond ##1 idle
			&& $stable(st.status[ST_Z:ST_C]))
		else $error("call not two cycles or flags moved");

	a_wdt_clear: assert property ( // RULE6
		instrGo && opIn == OP_CLEAR_WATCHDOG_INSTR |=> st.wdt == ZERO8
			&& st.status[ST_TO] && st.status[ST_PD])
		else $error("watchdog clear incomplete");

	a_pre_wdt_clr: assert property ( // RULE7
		instrGo && opIn == OP_CLEAR_WATCHDOG_INSTR && st.psaWdt |=> st.pre == ZERO8)
		else $error("prescaler not cleared");

	a_pre_tmr_keep: assert property ( // RULE7
		instrGo && opIn == OP_CLEAR_WATCHDOG_INSTR && !st.psaWdt
			|=> st.pre == $past(st.pre) + ONE8)
		else $error("prescaler disturbed while timer owns it");

	a_clear_file_instr_clears: assert property ( // RULE8
		instrGo && opIn == OP_CLEAR_FILE_INSTR |=> st.files[$past(fileIn)] == ZERO8
			&& st.status[ST_Z])
		else $error("file register not cleared");

	a_dest_working: assert property ( // RULE9
		instrGo && !destIn && (opIn == OP_COMPLEMENT_FILE_INSTR || opIn == OP_DECREMENT_FILE_INSTR
			|| opIn == OP_INCREMENT_FILE_INSTR) |=> st.files == $past(st.files)
			&& st.w == $past(aluOut.result))
		else $error("result not routed to working register");

	a_complement_file_instr_invert: assert property ( // RULE10
		instrGo && destIn && opIn == OP_COMPLEMENT_FILE_INSTR
			|=> st.files[$past(fileIn)] == ~$past(operand)
			&& st.status[ST_Z] == isZero(~$past(operand)))
		else $error("complement result wrong");

	a_decrement_file_instr_result: assert property ( // RULE11
		instrGo && destIn && opIn == OP_DECREMENT_FILE_INSTR
			|=> st.files[$past(fileIn)] == $past(operand) - ONE8)
		else $error("decrement result wrong");

	a_increment_file_instr_result: assert property ( // RULE12
		instrGo && destIn && opIn == OP_INCREMENT_FILE_INSTR
			|=> st.files[$past(fileIn)] == $past(operand) + ONE8)
		else $error("increment result wrong");

	a_incdec_wrap: assert property ( // RULE13
		instrGo && (opIn == OP_INCREMENT_FILE_INSTR || opIn == OP_DECREMENT_FILE_INSTR)
			|=> $stable(st.status[ST_DC:ST_C])
			&& (st.status[ST_Z] == ($past(operand)
			== ($past(opIn) == OP_INCREMENT_FILE_INSTR ? ALL8 : ONE8))))
		else $error("wrap or carry handling wrong");

	a_clear_working_instr_keeps_f: assert property ( // RULE1
		instrGo && opIn == OP_CLEAR_WORKING_INSTR |=> st.files == $past(st.files))
		else $error("clear working disturbed file registers");

	a_call_pc_hold: assert property ( // RULE5
		callIssued |=> st.pc == $past(st.pc)
			&& $stable(st.status[ST_Z:ST_C]))
		else $error("call first cycle moved counter or flags");

	a_clear_watchdog_instr_keeps: assert property ( // RULE6
		instrGo && opIn == OP_CLEAR_WATCHDOG_INSTR |=> st.w == $past(st.w)
			&& st.files == $past(st.files))
		else $error("watchdog clear disturbed data registers");

	a_clear_file_instr_keeps_w: assert property ( // RULE8
		instrGo && opIn == OP_CLEAR_FILE_INSTR |=> st.w == $past(st.w))
		else $error("clear file disturbed working register");

	a_dest_file: assert property ( // RULE9
		instrGo && destIn && (opIn == OP_COMPLEMENT_FILE_INSTR || opIn == OP_DECREMENT_FILE_INSTR
			|| opIn == OP_INCREMENT_FILE_INSTR) |=> st.w == $past(st.w))
		else $error("result leaked into working register");

	a_complement_file_instr_to_w: assert property ( // RULE10
		instrGo && !destIn && opIn == OP_COMPLEMENT_FILE_INSTR
			|=> st.w == ~$past(operand))
		else $error("complement into working register wrong");

	a_decrement_file_instr_to_w: assert property ( // RULE11
		instrGo && !destIn && opIn == OP_DECREMENT_FILE_INSTR
			|=> st.w == $past(operand) - ONE8
			&& st.status[ST_Z] == isZero($past(operand) - ONE8))
		else $error("decrement into working register wrong");

	a_increment_file_instr_to_w: assert property ( // RULE12
		instrGo && !destIn && opIn == OP_INCREMENT_FILE_INSTR
			|=> st.w == $past(operand) + ONE8)
		else $error("increment into working register wrong");

endmodule // cxe_exec_core

//--- testbench/cxe_prog_mem.sv
/*
 * cxe_prog_mem: program memory model handing instruction words by index.
 * assumes the instruction register layout of the core's package.
 */
module cxe_prog_mem
	import cxe_pkg::*;
(
	input wire logic [3:0] addr,
	output logic [31:0] word
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// program
	// ----------------------------------------------------------------
	function automatic logic [31:0] enc(cxe_op_t op, logic [4:0] f,
		logic d);
		return {22'h00_0000, d, f, op};
	endfunction

	always_comb begin
		case (addr)
			4'h0: word = enc(OP_CLEAR_WORKING_INSTR, 5'h00, 1'b0);
			4'h1: word = enc(OP_CLEAR_FILE_INSTR, 5'h1F, 1'b0);
			4'h2: word = enc(OP_COMPLEMENT_FILE_INSTR, 5'h03, 1'b0);
			4'h3: word = enc(OP_COMPLEMENT_FILE_INSTR, 5'h04, 1'b1);
			4'h4: word = enc(OP_DECREMENT_FILE_INSTR, 5'h05, 1'b0);
			4'h5: word = enc(OP_DECREMENT_FILE_INSTR, 5'h06, 1'b1);
			4'h6: word = enc(OP_INCREMENT_FILE_INSTR, 5'h07, 1'b0);
			4'h7: word = enc(OP_INCREMENT_FILE_INSTR, 5'h00, 1'b1);
			default: word = enc(OP_NOP, 5'h00, 1'b0);
		endcase
	end
endmodule // cxe_prog_mem

//--- testbench/tb.sv
/*
 * tb: self-checking bench for the execution core over APB.
 * assumes zero-wait APB answers except during the second call cycle.
 */
module tb
	import cxe_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	`define CHK(n, e, g) begin checkCount++; if ((e) !== (g)) begin \
		failures++; $display("wrong value %s exp %h got %h", n, e, g); \
		end end

	localparam logic [23:0] PAD = 24'h00_0000;
	localparam logic [31:0] NONE = 32'h0000_0000;
	localparam logic [31:0] B8 = 32'h0000_00FF;
	localparam int LIMIT = 20;
	typedef struct packed {
		logic [31:0] d;
		logic [31:0] m;
		logic e;
	} cxe_note_t;
	logic core_clk;
	logic reset_n;
	cxe_apb_req_t req;
	cxe_apb_rsp_t rsp;
	cxe_note_t notes[$];
	cxe_note_t nt;
	int failures = 0;
	int checkCount = 0;
	int seed = 49;
	logic [3:0] pmAddr;
	logic [31:0] pmWord;

	cxe_exec_core dut (.core_clk(core_clk), .reset_n(reset_n),
		.apbReq(req), .apbRsp(rsp));
	cxe_prog_mem pm (.addr(pmAddr), .word(pmWord));

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// ----------------------------------------------------------------
	// read monitor
	// ----------------------------------------------------------------
	always @(negedge core_clk) begin
		if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite) begin
			nt = notes.pop_front();
			if (nt.m !== NONE) begin
				`CHK("prdata", nt.d & nt.m, rsp.prdata & nt.m)
				`CHK("pslverr", nt.e, rsp.pslverr)
			end
		end
	end

	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	task automatic wrapUp();
		$display("checks %0d failures %0d", checkCount, failures);
		if (failures == 0 && checkCount > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rdv);
		int n;
		n = 0;
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= wd;
		@(posedge core_clk);
		req.penable <= 1'b1;
		@(posedge core_clk);
		while (rsp.pready !== 1'b1 && n < LIMIT) begin
			n++;
			@(posedge core_clk);
		end
		rdv = rsp.prdata;
		if (rsp.pready !== 1'b1) begin
			failures++;
			wrapUp();
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		xfer(1'b1, a, d, x);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic [31:0] m, input logic err);
		logic [31:0] x;
		notes.push_back('{e, m, err});
		xfer(1'b0, a, NONE, x);
	endtask

	task automatic raw(input logic [11:0] a, output logic [31:0] x);
		notes.push_back('{NONE, NONE, 1'b0});
		xfer(1'b0, a, NONE, x);
	endtask

	task automatic idle(input int n);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		repeat (n) @(posedge core_clk);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] x;
		logic [31:0] y;
		logic [7:0] w0;
		logic [7:0] fv;
		logic [7:0] r;
		logic [7:0] k;
		logic [10:0] pc0;
		logic [11:0] fa;
		cxe_op_t op;
		logic dst;
		logic z;
		req = '0;
		reset_n = 1'b0;
		pmAddr = 4'h0;
		repeat (16) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		rd(ADDR_STATUS, 32'h0000_0018, B8, 1'b0);
		rd(12'h020, NONE, 32'hFFFF_FFFF, 1'b1);
		for (int p = 0; p < 3; p++) begin
			for (int i = 0; i < 8; i++) begin
				pmAddr = i[3:0];
				x = $random(seed);
				w0 = x[7:0];
				z = x[8];
				wr(ADDR_WREG, {PAD, w0});
				op = cxe_op_t'(pmWord[3:0]);
				fa = ADDR_FILE_BASE + {5'h00, pmWord[8:4], 2'b00};
				dst = pmWord[9];
				fv = p == 2 ? 8'h00 : (op == OP_DECREMENT_FILE_INSTR ? 8'h01 : 8'hFF);
				fv = p == 0 ? x[23:16] : fv;
				wr(fa, {PAD, fv});
				wr(ADDR_STATUS, {29'h0000_0000, z, 2'b11});
				wr(ADDR_INSTR, pmWord);
				case (op)
					OP_CLEAR_WORKING_INSTR, OP_CLEAR_FILE_INSTR: r = 8'h00;
					OP_COMPLEMENT_FILE_INSTR: r = ~fv;
					OP_DECREMENT_FILE_INSTR: r = fv - 8'h01;
					default: r = fv + 8'h01;
				endcase
				dst = op == OP_CLEAR_FILE_INSTR ? 1'b1 : (op == OP_CLEAR_WORKING_INSTR ? 1'b0 : dst);
				rd(ADDR_WREG, {PAD, dst ? w0 : r}, B8, 1'b0);
				rd(fa, {PAD, dst ? r : fv}, B8, 1'b0);
				rd(ADDR_STATUS, {29'h0000_0000, r == 8'h00, 2'b11},
					32'h0000_00E7, 1'b0);
			end
		end
		$display("test alu done");
		for (int p = 0; p < 4; p++) begin
			x = $random(seed);
			pc0 = {x[10:9], 1'b1, x[7:0]};
			k = x[23:16];
			wr(ADDR_STATUS, {25'h000_0000, p[1:0], 5'h00});
			wr(ADDR_PC, {21'h00_0000, pc0});
			wr(ADDR_INSTR, {8'h00, k, 16'h0006});
			rd(ADDR_CTRL, 32'h0000_0002, 32'h0000_0002, 1'b0);
			rd(ADDR_CTRL, NONE, 32'h0000_0002, 1'b0);
			rd(ADDR_STACK, {21'h00_0000, pc0 + PC_STEP},
				32'h0000_07FF, 1'b0);
			rd(ADDR_PC, {21'h00_0000, p[1:0], 1'b0, k},
				32'h0000_07FF, 1'b0);
			rd(ADDR_STATUS, {25'h000_0000, p[1:0], 5'h00},
				32'h0000_00E7, 1'b0);
		end
		wr(ADDR_PC, {21'h00_0000, pc0});
		wr(ADDR_INSTR, NONE);
		rd(ADDR_PC, {21'h00_0000, pc0 + PC_STEP}, 32'h0000_07FF, 1'b0);
		$display("test call done");
		wr(ADDR_CTRL, NONE);
		idle(300);
		rd(ADDR_STATUS, NONE, 32'h0000_0010, 1'b0);
		raw(ADDR_WDT, x);
		wr(ADDR_INSTR, 32'h0000_0007);
		raw(ADDR_WDT, y);
		`CHK("watchdog", 8'h00, y[7:0])
		`CHK("prescaler step", 8'h04, y[15:8] - x[15:8])
		rd(ADDR_STATUS, 32'h0000_0018, 32'h0000_0018, 1'b0);
		wr(ADDR_STATUS, NONE);
		rd(ADDR_STATUS, 32'h0000_0018, 32'h0000_0018, 1'b0);
		wr(ADDR_CTRL, 32'h0000_0001);
		idle(40);
		wr(ADDR_INSTR, 32'h0000_0007);
		raw(ADDR_WDT, y);
		`CHK("watchdog and prescaler", 16'h0000, y[15:0])
		rd(ADDR_CTRL, 32'h0000_0001, 32'h0000_0003, 1'b0);
		idle(2);
		$display("test watchdog done");
		wrapUp();
	end
endmodule // tb
